// ===== hdl/vce_top.sv
// Video capture engine: register slave, pixel capture and memory writer
`timescale 1ns/1ps
// Function
// - Colour adjust: three 8-bit values, direction bits
// - Key write resets engine 200 cycles later
// - Drop leading lines of each field
// - Reset pin resets whole engine and master
// - Split luma, chroma to separate memory areas
// - One-shot uses buffer one, stops after frame
// - Ping-pong continues into next buffer without pause
// - Ping-pong stops when both buffers ready
// - Enabled capture-complete interrupt every frame end
// - Late address overwrite is not detected
// - Continuous mode alternates both buffer sets
// - Continuous mode never stops by itself
// - Mode bits: one-shot over ping-pong
// - Hardware sets ready bits, host clears
// - Reading interrupt status clears it
module vce_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic hw_reset_n,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic [1:0] hresp,
   input wire vce_pkg::vce_pix_t pix,
   output vce_pkg::vce_mst_t mst,
   input wire logic m_hready,
   output logic irq
);
   import vce_pkg::*;

   // ****************************************
   // Synchronisers
   // ****************************************
   logic [1:0] hwr_s_r;
   vce_pix_t px1_r, px2_r, px3_r;
   // Pin levels pass two flops before use
   always_ff @(posedge clk) begin
      if (rst) begin
         hwr_s_r <= 2'b11;
         px1_r <= '0;
         px2_r <= '0;
         px3_r <= '0;
      end else begin
         hwr_s_r <= {hwr_s_r[0], hw_reset_n};
         px1_r <= pix;
         px2_r <= px1_r;
         px3_r <= px2_r;
      end
   end
   logic [7:0] srst_cnt_r;
   wire srst_fire = (srst_cnt_r == 8'h01);
   wire sys_rst = rst | ~hwr_s_r[1];
   wire eng_rst = sys_rst | srst_fire;

   // ****************************************
   // Register slave
   // ****************************************
   logic [2:0] burst_r, irq_en_r, int_r;
   logic ovf_r, loss_r, last_r, wr_p_r;
   logic [1:0] rdy_r;
   logic [7:0] fcnt_r, ap_r;
   logic [10:0] ctrl_r;
   logic [31:0] b1y_r, b1c_r, b2y_r, b2c_r, fs_r, crop_r, key_r, hrd_r;
   logic [26:0] col_r;
   logic [3:0] skip_r;
   logic [2:0] int_set;
   logic [1:0] rdy_set;
   logic loss_set, ovf_set, fend;
   logic in_frm_r, bsel_r, one_done_r;
   wire take = hsel & hready & htrans[1];
   wire rd_take = take & ~hwrite;
   wire rc_int = rd_take & (haddr == OFS_INT_STS);
   wire rc_sts = rd_take & (haddr == OFS_STS);
   wire [31:0] fb_val = {16'h0, fcnt_r, 4'h0, last_r, loss_r, rdy_r};
   // Read selection in the address phase
   wire [31:0] rd_val =
      (haddr == OFS_BURST) ? {29'h0, burst_r} :
      (haddr == OFS_IRQ_EN) ? {29'h0, irq_en_r} :
      (haddr == OFS_INT_STS) ? {29'h0, int_r} :
      (haddr == OFS_STS) ? {31'h0, ovf_r} :
      (haddr == OFS_CTRL) ? {21'h0, ctrl_r} :
      (haddr == OFS_B1Y) ? b1y_r :
      (haddr == OFS_B1C) ? b1c_r :
      (haddr == OFS_B2Y) ? b2y_r :
      (haddr == OFS_B2C) ? b2c_r :
      (haddr == OFS_FB) ? fb_val :
      (haddr == OFS_FS) ? fs_r :
      (haddr == OFS_CROP) ? crop_r :
      (haddr == OFS_COL) ? {5'h0, col_r} :
      (haddr == OFS_SRST) ? key_r :
      (haddr == OFS_SKIP) ? {28'h0, skip_r} : 32'h0;
   // Data-phase write strobes
   wire w_fb = wr_p_r & (ap_r == OFS_FB);
   wire w_key = wr_p_r & (ap_r == OFS_SRST);
   assign hrdata = hrd_r;
   assign hreadyout = 1'b1;
   assign hresp = 2'b00;
   // Address phase capture and read data
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_p_r <= 1'b0;
         ap_r <= 8'h00;
         hrd_r <= 32'h0;
      end else begin
         wr_p_r <= take & hwrite;
         ap_r <= haddr;
         hrd_r <= rd_take ? rd_val : 32'h0;
      end
   end
   // Plain read-write registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         burst_r <= RST_BURST;
         irq_en_r <= 3'h0;
         ctrl_r <= 11'h0;
         b1y_r <= RST_BASE;
         b1c_r <= RST_BASE;
         b2y_r <= RST_BASE;
         b2c_r <= RST_BASE;
         fs_r <= RST_FS;
         crop_r <= 32'h0;
         col_r <= 27'h0;
         key_r <= 32'h0;
         skip_r <= 4'h0;
      end else if (wr_p_r) begin
         unique case (ap_r)
            OFS_BURST: burst_r <= hwdata[2:0];
            OFS_IRQ_EN: irq_en_r <= hwdata[2:0];
            OFS_CTRL: ctrl_r <= hwdata[10:0] & CTL_MASK;
            OFS_B1Y: b1y_r <= hwdata;
            OFS_B1C: b1c_r <= hwdata;
            OFS_B2Y: b2y_r <= hwdata;
            OFS_B2C: b2c_r <= hwdata;
            OFS_FS: fs_r <= hwdata;
            OFS_CROP: crop_r <= hwdata & CROP_MASK;
            OFS_COL: col_r <= hwdata[26:0];
            OFS_SRST: key_r <= hwdata;
            OFS_SKIP: skip_r <= hwdata[3:0];
            default: ;
         endcase
      end
   end
   // Status flags: hardware set wins over host clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdy_r <= 2'b00;
         loss_r <= 1'b0;
         int_r <= 3'h0;
         ovf_r <= 1'b0;
         irq <= 1'b0;
      end else begin
         rdy_r <= (w_fb ? hwdata[1:0] : rdy_r) | rdy_set;
         loss_r <= (w_fb ? hwdata[2] : loss_r) | loss_set;
         int_r <= (rc_int ? 3'h0 : int_r) | int_set;
         ovf_r <= (rc_sts ? 1'b0 : ovf_r) | ovf_set;
         irq <= |(int_r & irq_en_r);
      end
   end
   // Frame counter and latest buffer
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fcnt_r <= 8'h0;
         last_r <= 1'b0;
      end else if (fend) begin
         fcnt_r <= fcnt_r + 8'h01;
         last_r <= bsel_r;
      end else if (w_fb) begin
         fcnt_r <= hwdata[15:8];
      end
   end
   // Keyed soft reset delay
   always_ff @(posedge clk) begin
      if (sys_rst | srst_fire)
         srst_cnt_r <= 8'h00;
      else if (w_key & (hwdata == SRST_KEY))
         srst_cnt_r <= SRST_CLKS;
      else if (srst_cnt_r != 8'h00)
         srst_cnt_r <= srst_cnt_r - 8'h01;
   end

   // ****************************************
   // Pixel stream decoding
   // ****************************************
   logic [7:0] h0_r, h1_r, h2_r;
   logic act_r, vbl_r, hrf_p_r;
   logic [1:0] age_r;
   wire sens = ctrl_r[CTL_SENSOR];
   wire neg = ctrl_r[CTL_NEG];
   wire pe = (px2_r.pclk ^ neg) & ~(px3_r.pclk ^ neg);
   wire [7:0] d = px2_r.d;
   wire hrf = px2_r.href ^ ctrl_r[CTL_HREF_LO];
   // Sensor vsync edges on every clock, since pclk stops outside frames
   wire vs_fall = px3_r.vsync & ~px2_r.vsync;
   wire vs_rise = ~px3_r.vsync & px2_r.vsync;
   // Timing reference codes of the embedded-sync stream
   wire tc = (h2_r == 8'hFF) & (h1_r == 8'h00) & (h0_r == 8'h00);
   wire sav = tc & ~d[4] & ~d[5];
   wire eav = tc & d[4];
   wire f6_st = sav & vbl_r;
   wire f6_en = tc & d[5] & ~vbl_r;
   wire fsel = (d[6] == ctrl_r[CTL_FIELD]);
   // Unified frame, field and line events
   wire fr_st = sens ? vs_fall : (pe & f6_st & fsel);
   wire fr_en = sens ? vs_rise : (pe & f6_en & ~fsel);
   wire fld_st = sens ? vs_fall : (pe & f6_st);
   wire ln_en = pe & (sens ? (hrf_p_r & ~hrf) : (eav & act_r));
   wire emit = pe & (sens ? hrf : (act_r & (age_r == 2'h3) & ~tc));
   wire [7:0] byt = sens ? d : h2_r;
   // Byte history and line activity
   always_ff @(posedge clk) begin
      if (eng_rst) begin
         {h0_r, h1_r, h2_r} <= 24'h0;
         act_r <= 1'b0;
         vbl_r <= 1'b1;
         age_r <= 2'h0;
         hrf_p_r <= 1'b0;
      end else if (pe) begin
         {h2_r, h1_r, h0_r} <= {h1_r, h0_r, d};
         hrf_p_r <= hrf;
         if (tc)
            vbl_r <= d[5];
         if (sav)
            age_r <= 2'h0;
         else if (act_r & (age_r != 2'h3))
            age_r <= age_r + 2'h1;
         if (sav)
            act_r <= 1'b1;
         else if (eav)
            act_r <= 1'b0;
      end
   end

   // ****************************************
   // Frame sequencing
   // ****************************************
   logic [3:0] lcnt_r;
   logic par_r;
   logic [1:0] ph_r;
   logic [31:0] yp_r, cp_r;
   wire en = ctrl_r[CTL_EN];
   wire one = ctrl_r[CTL_ONE];
   wire pp = ~one & ctrl_r[CTL_PP];
   wire halt = one_done_r | (pp & (rdy_r == 2'b11));
   wire go = en & ~halt;
   wire keep = (lcnt_r >= skip_r);
   assign fend = fr_en & in_frm_r;
   assign rdy_set = fend ? (bsel_r ? 2'b10 : 2'b01) : 2'b00;
   assign loss_set = fr_st & en & halt & ~sens;
   assign int_set = {ln_en & in_frm_r, loss_set, fend};
   // Buffer selection and frame enable
   always_ff @(posedge clk) begin
      if (eng_rst | ~en) begin
         in_frm_r <= 1'b0;
         bsel_r <= 1'b0;
         one_done_r <= 1'b0;
      end else if (fend) begin
         in_frm_r <= 1'b0;
         one_done_r <= one;
         bsel_r <= one ? 1'b0 : ~bsel_r;
      end else if (fr_st & go) begin
         in_frm_r <= 1'b1;
      end
   end
   // Per-field line count, chroma line parity and byte phase
   always_ff @(posedge clk) begin
      if (eng_rst | fld_st) begin
         lcnt_r <= 4'h0;
         par_r <= 1'b0;
         ph_r <= 2'h0;
      end else if (ln_en) begin
         if (lcnt_r != 4'hF)
            lcnt_r <= lcnt_r + 4'h1;
         if (keep)
            par_r <= ~par_r;
         ph_r <= 2'h0;
      end else if (emit) begin
         ph_r <= ph_r + 2'h1;
      end
   end

   // ****************************************
   // Colour adjust and word packing
   // ****************************************
   function automatic logic [7:0] adj(input logic [7:0] v, input logic [7:0] a,
                                      input logic up);
      logic [8:0] s;
      s = up ? ({1'b0, v} + {1'b0, a}) : ({1'b0, v} - {1'b0, a});
      adj = s[8] ? (up ? 8'hFF : 8'h00) : s[7:0];
   endfunction
   wire is_y = ctrl_r[CTL_YFIRST] ? ~ph_r[0] : ph_r[0];
   wire is_cb = ~ph_r[1];
   wire [7:0] y_adj = adj(byt, col_r[23:16], col_r[COL_Y_DIR]);
   wire [7:0] c_amt = is_cb ? col_r[15:8] : col_r[7:0];
   wire c_up = is_cb ? col_r[COL_CB_DIR] : col_r[COL_CR_DIR];
   wire [7:0] c_adj = adj(byt, c_amt, c_up);
   wire wr_ok = emit & in_frm_r & keep;
   wire c_ok = ctrl_r[CTL_422] | ~par_r;
   wire ypush = wr_ok & is_y;
   wire cpush = wr_ok & ~is_y & c_ok;
   logic [31:0] yw_r, cw_r, pyd_r, pcd_r, pya_r, pca_r;
   logic [1:0] yn_r, cn_r;
   logic py_r, pc_r, msel_r;
   vce_mst_st_t st_r;
   wire ydone = ypush & (yn_r == 2'h3);
   wire cdone = cpush & (cn_r == 2'h3);
   wire y_tk = (st_r == M_ADDR) & m_hready & ~msel_r;
   wire c_tk = (st_r == M_ADDR) & m_hready & msel_r;
   wire y_ld = ydone & (~py_r | y_tk);
   wire c_ld = cdone & (~pc_r | c_tk);
   assign ovf_set = (ydone & ~y_ld) | (cdone & ~c_ld);
   // Shift bytes into words, first byte lowest
   always_ff @(posedge clk) begin
      if (eng_rst | ln_en) begin
         yn_r <= 2'h0;
         cn_r <= 2'h0;
      end else begin
         if (ypush)
            yn_r <= yn_r + 2'h1;
         if (cpush)
            cn_r <= cn_r + 2'h1;
      end
      if (ypush)
         yw_r <= {y_adj, yw_r[31:8]};
      if (cpush)
         cw_r <= {c_adj, cw_r[31:8]};
   end
   // Write pointers; bases sampled at frame start, never checked
   always_ff @(posedge clk) begin
      if (eng_rst) begin
         yp_r <= 32'h0;
         cp_r <= 32'h0;
      end else if (fr_st & go & ~in_frm_r) begin
         yp_r <= bsel_r ? b2y_r : b1y_r;
         cp_r <= bsel_r ? b2c_r : b1c_r;
      end else begin
         if (y_ld)
            yp_r <= yp_r + 32'h4;
         if (c_ld)
            cp_r <= cp_r + 32'h4;
      end
   end
   // Words waiting for the memory writer
   always_ff @(posedge clk) begin
      if (eng_rst) begin
         py_r <= 1'b0;
         pc_r <= 1'b0;
      end else begin
         py_r <= (py_r & ~y_tk) | y_ld;
         pc_r <= (pc_r & ~c_tk) | c_ld;
      end
      if (y_ld) begin
         pyd_r <= {y_adj, yw_r[31:8]};
         pya_r <= yp_r;
      end
      if (c_ld) begin
         pcd_r <= {c_adj, cw_r[31:8]};
         pca_r <= cp_r;
      end
   end

   // ****************************************
   // Memory writer: single word transfers
   // ****************************************
   // Luma first; address phase then data phase
   always_ff @(posedge clk) begin
      if (eng_rst) begin
         st_r <= M_IDLE;
         msel_r <= 1'b0;
         mst <= '{haddr: 32'h0, htrans: HT_IDLE, hwrite: 1'b1,
                  hsize: HSIZE_WORD, hburst: HBURST_SINGLE, hwdata: 32'h0};
      end else begin
         unique case (st_r)
            M_IDLE: if (py_r | pc_r) begin
               msel_r <= ~py_r;
               mst.haddr <= py_r ? pya_r : pca_r;
               mst.htrans <= HT_NONSEQ;
               st_r <= M_ADDR;
            end
            M_ADDR: if (m_hready) begin
               mst.htrans <= HT_IDLE;
               mst.hwdata <= msel_r ? pcd_r : pyd_r;
               st_r <= M_DATA;
            end
            M_DATA: if (m_hready) begin
               st_r <= M_IDLE;
            end
            default: st_r <= M_IDLE;
         endcase
      end
   end
endmodule

// ===== hdl/vce_pkg.sv
// Constants and types shared by the video capture engine
package vce_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] OFS_BURST = 8'h00;
   localparam logic [7:0] OFS_IRQ_EN = 8'h04;
   localparam logic [7:0] OFS_INT_STS = 8'h08;
   localparam logic [7:0] OFS_STS = 8'h0C;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam logic [7:0] OFS_B1Y = 8'h14;
   localparam logic [7:0] OFS_B1C = 8'h18;
   localparam logic [7:0] OFS_B2Y = 8'h20;
   localparam logic [7:0] OFS_B2C = 8'h24;
   localparam logic [7:0] OFS_FB = 8'h2C;
   localparam logic [7:0] OFS_FS = 8'h30;
   localparam logic [7:0] OFS_CROP = 8'h38;
   localparam logic [7:0] OFS_COL = 8'h3C;
   localparam logic [7:0] OFS_SRST = 8'h40;
   localparam logic [7:0] OFS_SKIP = 8'h44;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTL_EN = 0;
   localparam int CTL_HREF_LO = 1;
   localparam int CTL_SENSOR = 2;
   localparam int CTL_YFIRST = 3;
   localparam int CTL_ONE = 5;
   localparam int CTL_422 = 6;
   localparam int CTL_FIELD = 7;
   localparam int CTL_PP = 8;
   localparam int CTL_NEG = 9;
   localparam int COL_CR_DIR = 24;
   localparam int COL_CB_DIR = 25;
   localparam int COL_Y_DIR = 26;
   localparam logic [10:0] CTL_MASK = 11'h7EF;
   localparam logic [31:0] CROP_MASK = 32'h03FF03FF;
   // ****************************************
   // Reset values, key and timing
   // ****************************************
   localparam logic [2:0] RST_BURST = 3'h5;
   localparam logic [31:0] RST_FS = 32'h02D001E6;
   localparam logic [31:0] RST_BASE = 32'hFFFFFFFF;
   localparam logic [31:0] SRST_KEY = 32'h76543210;
   localparam logic [7:0] SRST_CLKS = 8'hC8;
   localparam logic [1:0] HT_IDLE = 2'h0;
   localparam logic [1:0] HT_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [2:0] HBURST_SINGLE = 3'h0;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      M_IDLE = 2'b00,
      M_ADDR = 2'b01,
      M_DATA = 2'b10
   } vce_mst_st_t;
   typedef struct packed {
      logic pclk;
      logic href;
      logic vsync;
      logic [7:0] d;
   } vce_pix_t;
   typedef struct packed {
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [2:0] hburst;
      logic [31:0] hwdata;
   } vce_mst_t;
endpackage

// ===== tb/vce_cam.sv
// Camera sensor model driving the pixel pins of the capture engine
`timescale 1ns/1ps
module vce_cam
   import vce_pkg::*;
(
   input wire logic go,
   output vce_pix_t pix,
   output logic busy
);
   initial begin
      pix = '{pclk: 1'b0, href: 1'b0, vsync: 1'b1, d: 8'h00};
      busy = 1'b0;
   end
   // ****************************************
   // Frame of two lines, four pixels each, UYVY order
   // ****************************************
   // The pixel clock runs only inside the frame; outside href the bus toggles
   always @(posedge go) begin
      busy = 1'b1;
      #400 pix.vsync = 1'b0;
      for (int l = 0; l < 2; l++) begin
         for (int b = 0; b < 10; b++) begin
            pix.href = (b < 8);
            pix.d = (b >= 8) ? ~pix.d : 8'((b[0] ? 8'h10 : 8'h80) + 4 * l + b / 2);
            #200 pix.pclk = 1'b1;
            #200 pix.pclk = 1'b0;
         end
      end
      #800 pix.vsync = 1'b1;
      #800 busy = 1'b0;
   end
endmodule

// ===== tb/vce_top_chk.sv
// Port checker for the video capture engine
`timescale 1ns/1ps
module vce_top_chk
   import vce_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hw_reset_n,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic [1:0] hresp,
   input wire vce_pix_t pix,
   input wire vce_mst_t mst,
   input wire logic m_hready,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic wa_r;
   logic [7:0] wadr_r;
   // Track register write address phases
   always_ff @(posedge clk) begin
      wa_r <= !rst && hsel && hready && htrans[1] && hwrite;
      wadr_r <= haddr;
   end
   // Decoded bus events
   wire key_wr = wa_r && wadr_r == OFS_SRST && hwdata == SRST_KEY;
   wire en_off = wa_r && wadr_r == OFS_IRQ_EN && hwdata[2:0] == 3'h0;
   wire rd_take = hsel && hready && htrans[1] && !hwrite;
   wire mtake = mst.htrans == HT_NONSEQ && m_hready;
   // ****************************************
   // Assertions
   // ****************************************
   AST_HREADY: assert property (hreadyout == 1'b1) else $error("slave inserted wait");
   AST_OKAY: assert property (hresp == 2'b00) else $error("slave response not okay");
   AST_MST_FORM: assert property (mst.htrans != HT_IDLE |-> mst.htrans == HT_NONSEQ && mst.hwrite
      && mst.hsize == HSIZE_WORD && mst.hburst == HBURST_SINGLE) else $error("bad master form");
   AST_MST_HOLD: assert property (mst.htrans == HT_NONSEQ && !m_hready |=>
      mst.htrans == HT_NONSEQ && $stable(mst.haddr)) else $error("master dropped request");
   AST_MST_GAP: assert property (mtake |=> mst.htrans == HT_IDLE ##1 mst.htrans == HT_IDLE)
      else $error("master transfers too close");
   AST_RD_IDLE: assert property (!$past(rd_take) |-> hrdata == 32'h00000000)
      else $error("read data outside data phase");
   AST_HW_RST: assert property (!hw_reset_n [*4] |-> mst.htrans == HT_IDLE && irq == 1'b0
      && mst.hwdata == 32'h00000000) else $error("reset pin ignored");
   AST_SRST: assert property (key_wr |-> ##201 mst.htrans == HT_IDLE)
      else $error("soft reset did not idle master");
   AST_IRQ_OFF: assert property (en_off |-> ##2 irq == 1'b0)
      else $error("masked interrupt still high");
endmodule
bind vce_top vce_top_chk u_chk (.clk(clk), .rst(rst), .hw_reset_n(hw_reset_n), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pix(pix), .mst(mst),
   .m_hready(m_hready), .irq(irq));

// ===== tb/tb_top.sv
// Register and frame capture tests of the video capture engine
`timescale 1ns/1ps
module tb_top;
   import vce_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hw_reset_n = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic hready = 1'b1;
   logic m_hready = 1'b1;
   logic go = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h00000000;
   logic irq, hreadyout, busy, dp;
   logic [1:0] hresp;
   logic [31:0] hrdata, rv, pa;
   vce_pix_t pix;
   vce_mst_t mst;
   logic [31:0] mem [logic [31:0]];
   int miscompares = 0;
   int comparisons = 0;
   int cyc = 0;
   logic [7:0] ra [8] = '{OFS_BURST, OFS_FS, OFS_B1Y, OFS_B2C, OFS_CTRL, OFS_COL, OFS_SKIP, 8'h1C};
   logic [31:0] re [8] = '{32'h5, RST_FS, RST_BASE, RST_BASE, 0, 0, 0, 0};
   always #25 clk = ~clk;
   vce_top dut (.clk(clk), .rst(rst), .hw_reset_n(hw_reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pix(pix), .mst(mst), .m_hready(m_hready),
      .irq(irq));
   vce_cam cam (.go(go), .pix(pix), .busy(busy));
   // Memory side: stall every third cycle, record completed writes
   initial dp = 1'b0;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      m_hready <= (cyc % 3) != 0;
      if (dp && m_hready) mem[pa] = mst.hwdata;
      if (mst.htrans == HT_NONSEQ && m_hready) begin
         pa = mst.haddr;
         dp = 1'b1;
      end else if (m_hready) dp = 1'b0;
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic step;
      @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      hsel = 1'b1; htrans = HT_NONSEQ; hwrite = 1'b1; haddr = a;
      step;
      hsel = 1'b0; htrans = HT_IDLE; hwrite = 1'b0; hwdata = d;
      step;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      hsel = 1'b1; htrans = HT_NONSEQ; hwrite = 1'b0; haddr = a;
      step;
      hsel = 1'b0; htrans = HT_IDLE; rv = hrdata;
      step;
      chk(rv & m, exp);
   endtask
   task automatic wrap_up;
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic frame;
      int n;
      n = 0;
      go = 1'b1;
      step;
      go = 1'b0;
      while (busy && n < 2000) begin
         step;
         n++;
      end
      if (n >= 2000) begin
         miscompares++;
         wrap_up;
      end
      repeat (40) step;
   endtask
   task automatic mchk(input logic [31:0] a, input logic [31:0] exp);
      chk(mem.exists(a) ? mem[a] : ~exp, exp);
   endtask
   // Two lines give one luma and one chroma word each, first byte lowest
   task automatic fcheck(input logic [31:0] y, input logic [31:0] c);
      mchk(y, 32'h13121110);
      mchk(y + 4, 32'h17161514);
      mchk(c, 32'h83828180);
      mchk(c + 4, 32'h87868584);
      chk(mem.size(), 4);
      mem.delete();
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (20) step;
      rst = 1'b0;
      for (int i = 0; i < 8; i++) rchk(ra[i], re[i], 32'hFFFFFFFF);
      wr(OFS_COL, 32'hFFFFFFFF);
      rchk(OFS_COL, 32'h07FFFFFF, 32'hFFFFFFFF);
      wr(OFS_SKIP, 32'hFFFFFFFF);
      rchk(OFS_SKIP, 32'h0000000F, 32'hFFFFFFFF);
      wr(OFS_SKIP, 32'h0);
      wr(OFS_COL, 32'h0);
      wr(8'h1C, 32'h12345678);
      rchk(8'h1C, 32'h0, 32'hFFFFFFFF);
      wr(OFS_B1Y, 32'h1000);
      wr(OFS_B1C, 32'h2000);
      wr(OFS_B2Y, 32'h3000);
      wr(OFS_B2C, 32'h4000);
      wr(OFS_CROP, 32'h0);
      wr(OFS_IRQ_EN, 32'h1);
      wr(OFS_FB, 32'h0);
      wr(OFS_CTRL, 32'h165);
      frame;
      fcheck(32'h1000, 32'h2000);
      rchk(OFS_FB, 32'h1, 32'h3);
      chk({31'h0, irq}, 32'h1);
      rchk(OFS_INT_STS, 32'h1, 32'h1);
      step;
      rchk(OFS_INT_STS, 32'h0, 32'h1);
      frame;
      chk(mem.size(), 0);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_FB, 32'h0);
      wr(OFS_CTRL, 32'h145);
      frame;
      fcheck(32'h1000, 32'h2000);
      frame;
      fcheck(32'h3000, 32'h4000);
      frame;
      chk(mem.size(), 0);
      rchk(OFS_FB, 32'h3, 32'h3);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_FB, 32'h0);
      wr(OFS_CTRL, 32'h045);
      frame;
      fcheck(32'h1000, 32'h2000);
      frame;
      fcheck(32'h3000, 32'h4000);
      wr(OFS_IRQ_EN, 32'h0);
      wr(OFS_B1Y, 32'h5000);
      wr(OFS_B1C, 32'h6000);
      frame;
      fcheck(32'h5000, 32'h6000);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_SRST, SRST_KEY);
      repeat (210) step;
      rchk(OFS_CTRL, 32'h45, 32'hFFFFFFFF);
      frame;
      fcheck(32'h5000, 32'h6000);
      hw_reset_n = 1'b0;
      repeat (10) step;
      hw_reset_n = 1'b1;
      repeat (4) step;
      rchk(OFS_CTRL, 32'h0, 32'hFFFFFFFF);
      rchk(OFS_B1Y, RST_BASE, 32'hFFFFFFFF);
      // One-shot, Y first, 4:2:0, first line skipped, colour adjusted
      wr(OFS_B1Y, 32'h7000);
      wr(OFS_B1C, 32'h8000);
      wr(OFS_COL, 32'h05020101);
      wr(OFS_SKIP, 32'h1);
      wr(OFS_FB, 32'h0);
      wr(OFS_CTRL, 32'h02D);
      frame;
      mchk(32'h7000, 32'h89888786);
      mchk(32'h8000, 32'h18151613);
      chk(mem.size(), 2);
      wrap_up;
   end
endmodule
